/* File: srw_host.sv */
// Purpose: host model that toggles the kick input
// Assumes: kick requests come as one cycle pulses
// Notes:   level holds while reset is active
`timescale 1ns/1ps
module srw_host (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       reset_n,
   input  wire logic       kick_req,
   input  wire logic       float_en,
   output logic      [1:0] kick
);
   logic lvl_q;
   // ***************************************************************
   // kick level
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lvl_q <= 1'b0;
      end else if (kick_req && reset_n) begin
         lvl_q <= ~lvl_q;
      end
   end
   // tri-stated port reads as mid level
   assign kick = float_en ? 2'b10 : {1'b0, lvl_q};
endmodule : srw_host

/* File: srw_pkg.sv */
// Purpose: constants for the supply reset watchdog supervisor
// Assumes: 50 MHz system clock
// Notes:   periods are counted in time base ticks
package srw_pkg;
   // ***************************************************************
   // time base
   // ***************************************************************
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned OSC_MILLI_HZ   = 10_240_000;   // 10.24 kHz
   // cycles per internal tick, rounded down; 64 bit product, 32 bit would overflow
   localparam int unsigned OSC_DIV        = 32'((64'(CLK_HZ) * 64'h3E8) / 64'(OSC_MILLI_HZ));
   // ***************************************************************
   // periods in milliseconds and in internal ticks
   // ***************************************************************
   localparam int unsigned RST_MS         = 50;
   localparam int unsigned WD_SHORT_MS    = 100;
   localparam int unsigned WD_LONG_MS     = 1600;
   localparam int unsigned RST_TICKS      = RST_MS * 10240 / 1000;
   localparam int unsigned WD_SHORT_TICKS = WD_SHORT_MS * 10240 / 1000;
   localparam int unsigned WD_LONG_TICKS  = WD_LONG_MS * 10240 / 1000;
   // external clock mode counts
   localparam int unsigned EXT_WD_NORMAL  = 1024;
   localparam int unsigned EXT_WD_LONG    = 4096;
   localparam int unsigned EXT_RST        = 512;
   localparam int unsigned CNT_W          = 15;
   // ***************************************************************
   // kick input level codes
   // ***************************************************************
   typedef enum logic [1:0] {
      KICK_LOW   = 2'b00,
      KICK_HIGH  = 2'b01,
      KICK_FLOAT = 2'b10
   } srw_kick_t;
endpackage : srw_pkg

/* File: srw_supervisor.sv */
// Purpose: reset supervisor with low supply reset and watchdog
// Assumes: supply flag and kick level code come from digitisers
// Notes:   long periods counted in ticks, never in clk cycles
//
// Behaviour
// R1: reset low while supply flag low
// R2: hold reset 50 ms after supply recovers
// R3: active high reset inverts active low reset
// R4: missed kick gives reset pulse
// R5: long timeout right after any reset
// R6: restart watchdog when reset ends
// R7: first kick after reset selects normal timeout
// R8: every kick edge restarts timeout count
// R9: steady kick gives reset each long timeout
// R10: floating kick disables watchdog
// R11: external clock counts 1024, 4096, 512
// R12: internal mode: timebase pin picks 100ms/1.6s
// R13: internal time base 10.24 kHz
// R14: source strap low uses timebase pin clock
// R15: expired output low until next kick
// R16: low supply forces expired output high
// R17: chip enable passes through when supply good
// R18: chip enable forced high when supply low
// R19: host kicks within 70 ms
// R20: host leaves kick port idle during init
// R21: supply low output follows supply flag
// R22: kick input has three levels
// R23: synchronise supply and kick before use
`timescale 1ns/1ps
module srw_supervisor
   import srw_pkg::*;
#(
   parameter int unsigned DIV = OSC_DIV
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       supply_low,
   input  wire logic [1:0] watchdog_kick_in,
   input  wire logic       timebase_source_select,
   input  wire logic       timebase_in,
   input  wire logic       ce_in_n,
   output logic            reset_n,
   output logic            reset,
   output logic            supply_low_n,
   output logic            watchdog_expired_n,
   output logic            ce_out_n
);
   import srw_pkg::*;

   typedef enum logic [1:0] {
      ST_SUPPLY = 2'b00,
      ST_HOLD   = 2'b01,
      ST_RUN    = 2'b10
   } srw_state_t;

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [4:0] raw;
   logic [4:0] syn;
   logic       low_s;
   logic [1:0] kick_s;
   logic       sel_s;
   logic       tb_s;

   assign raw = {supply_low, watchdog_kick_in, timebase_source_select, timebase_in};

   srw_sync #(.W(5)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    (raw),
      .q    (syn)
   ); // see R23

   assign low_s  = syn[4];
   assign kick_s = syn[3:2];
   assign sel_s  = syn[1];
   assign tb_s   = syn[0];

   // ***************************************************************
   // time base
   // ***************************************************************
   logic tick;

   srw_timebase #(.DIV(DIV)) u_tb (
      .clk          (clk),
      .nrst         (nrst),
      .use_internal (sel_s),
      .ext_clk_s    (tb_s),
      .tick         (tick)
   );

   // ***************************************************************
   // kick edge detection, only between high and low
   // ***************************************************************
   srw_kick_t kick_lvl;
   srw_kick_t kick_prev_q;
   logic      kick_active;
   logic      kick_edge;

   assign kick_lvl    = (kick_s == 2'b00) ? KICK_LOW :
                        (kick_s == 2'b01) ? KICK_HIGH : KICK_FLOAT;          // see R22
   assign kick_active = (kick_lvl != KICK_FLOAT);                            // see R10
   assign kick_edge   = kick_active && (kick_prev_q != KICK_FLOAT)
                        && (kick_lvl != kick_prev_q);                        // see R8

   always_ff @(posedge clk) begin
      if (!nrst) begin
         kick_prev_q <= KICK_FLOAT;
      end else begin
         kick_prev_q <= kick_lvl;
      end
   end

   // ***************************************************************
   // period selection
   // ***************************************************************
   function automatic logic [CNT_W-1:0] wd_limit(input logic internal, input logic pin,
                                                input logic is_long);
      if (!internal) begin
         wd_limit = is_long ? CNT_W'(EXT_WD_LONG) : CNT_W'(EXT_WD_NORMAL);   // see R11
      end else if (is_long || pin) begin
         wd_limit = CNT_W'(WD_LONG_TICKS);                                   // see R12
      end else begin
         wd_limit = CNT_W'(WD_SHORT_TICKS);                                  // see R12
      end
   endfunction : wd_limit

   logic [CNT_W-1:0] rst_limit;

   assign rst_limit = sel_s ? CNT_W'(RST_TICKS) : CNT_W'(EXT_RST);          // see R11

   // ***************************************************************
   // reset state machine
   // ***************************************************************
   srw_state_t       state_q;
   logic [CNT_W-1:0] rst_cnt_q;
   logic [CNT_W-1:0] wd_cnt_q;
   logic             long_q;
   logic             wd_timeout;

   assign wd_timeout = (state_q == ST_RUN) && kick_active && !kick_edge && tick
                       && (wd_cnt_q >= wd_limit(sel_s, tb_s, long_q) - CNT_W'(1));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_SUPPLY;
      end else if (low_s) begin
         state_q <= ST_SUPPLY;                                               // see R1
      end else begin
         case (state_q)
            ST_SUPPLY: state_q <= ST_HOLD;                                   // see R2
            ST_HOLD: begin
               if (tick && rst_cnt_q >= rst_limit - CNT_W'(1)) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (wd_timeout) begin
                  state_q <= ST_HOLD;                                        // see R4 R9
               end
            end
            default: state_q <= ST_SUPPLY;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || state_q != ST_HOLD) begin
         rst_cnt_q <= '0;
      end else if (tick) begin
         rst_cnt_q <= rst_cnt_q + CNT_W'(1);
      end
   end

   // watchdog count restarts at every reset end and every kick
   always_ff @(posedge clk) begin
      if (!nrst || state_q != ST_RUN || kick_edge || !kick_active) begin
         wd_cnt_q <= '0;                                                     // see R6 R8 R10
      end else if (tick) begin
         wd_cnt_q <= wd_cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || state_q != ST_RUN) begin
         long_q <= 1'b1;                                                     // see R5
      end else if (kick_edge) begin
         long_q <= 1'b0;                                                     // see R7
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdog_expired_n <= 1'b1;
      end else if (low_s) begin
         watchdog_expired_n <= 1'b1;                                         // see R16
      end else if (wd_timeout) begin
         watchdog_expired_n <= 1'b0;                                         // see R15
      end else if (kick_edge) begin
         watchdog_expired_n <= 1'b1;                                         // see R15
      end
   end

   assign reset_n      = (state_q == ST_RUN);                                // see R1 R2
   assign reset        = !reset_n;                                           // see R3
   assign supply_low_n = !low_s;                                             // see R21
   // combinational gate keeps chip enable delay short
   assign ce_out_n     = low_s ? 1'b1 : ce_in_n;                             // see R17 R18

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_low_clear;
      $fell(low_s);
   endsequence

   sequence s_hold_done;
      (state_q == ST_HOLD) ##1 (state_q == ST_RUN);
   endsequence

   sequence s_timeout_long;
      wd_timeout && long_q;
   endsequence

   sequence s_timeout_norm;
      wd_timeout && !long_q;
   endsequence

   sequence s_tick_int;
      (sel_s && tick) ##1 sel_s;
   endsequence

   sequence s_tick_ext;
      (!sel_s && tick) ##1 !sel_s;
   endsequence

   a_low_reset: assert property (@(posedge clk) disable iff (!nrst)
      low_s |-> ##1 !reset_n)                                                // see R1
      else $error("reset not asserted while supply low");

   a_hold_after: assert property (@(posedge clk) disable iff (!nrst)
      s_low_clear |-> !reset_n [*3])                                         // see R2
      else $error("reset released too early after supply");

   a_reset_inv: assert property (@(posedge clk) disable iff (!nrst)
      reset == !reset_n)                                                     // see R3
      else $error("reset outputs not complementary");

   a_wd_pulse: assert property (@(posedge clk) disable iff (!nrst)
      wd_timeout && !low_s |=> !reset_n && !watchdog_expired_n)              // see R4 R15
      else $error("timeout did not give reset pulse");

   a_long_after: assert property (@(posedge clk) disable iff (!nrst)
      $rose(reset_n) |-> long_q && wd_cnt_q == '0)                           // see R5 R6
      else $error("watchdog not restarted long after reset");

   a_kick_short: assert property (@(posedge clk) disable iff (!nrst)
      reset_n && kick_edge && !low_s |=> !long_q && wd_cnt_q == '0)          // see R7 R8
      else $error("kick did not restart count");

   a_float_off: assert property (@(posedge clk) disable iff (!nrst)
      !kick_active |-> !wd_timeout)                                          // see R10
      else $error("timeout while kick floating");

   a_expired_low: assert property (@(posedge clk) disable iff (!nrst)
      low_s |=> watchdog_expired_n)                                          // see R16
      else $error("expired output not high in low supply");

   a_ce_gate: assert property (@(posedge clk) disable iff (!nrst)
      low_s |-> ce_out_n)                                                    // see R18
      else $error("chip enable passed during low supply");

   a_supply_out: assert property (@(posedge clk) disable iff (!nrst)
      supply_low_n == !low_s)                                                // see R21
      else $error("supply low output wrong");

   // exact count at exit, the >= compare in the logic would hide an overshoot
   a_hold_len: assert property (@(posedge clk) disable iff (!nrst)   // see R2 R11 R12
      s_hold_done |-> $past(rst_cnt_q) == (sel_s ? CNT_W'(RST_TICKS - 1)
                                                 : CNT_W'(EXT_RST - 1)))
      else $error("reset hold length wrong");

   a_long_limit: assert property (@(posedge clk) disable iff (!nrst)   // see R5 R9 R11
      s_timeout_long |-> wd_cnt_q == (sel_s ? CNT_W'(WD_LONG_TICKS - 1)
                                            : CNT_W'(EXT_WD_LONG - 1)))
      else $error("long timeout length wrong");

   // straps assumed static, a mid run change may end a period early
   a_norm_limit: assert property (@(posedge clk) disable iff (!nrst)   // see R7 R11 R12
      s_timeout_norm |-> wd_cnt_q == (!sel_s ? CNT_W'(EXT_WD_NORMAL - 1) :
                                      tb_s   ? CNT_W'(WD_LONG_TICKS - 1) :
                                               CNT_W'(WD_SHORT_TICKS - 1)))
      else $error("normal timeout length wrong");

   a_ce_pass: assert property (@(posedge clk) disable iff (!nrst)   // see R17
      !low_s |-> ce_out_n == ce_in_n)
      else $error("chip enable not passed through");

   a_expired_set: assert property (@(posedge clk) disable iff (!nrst)   // see R15
      kick_edge && !low_s |=> watchdog_expired_n)
      else $error("kick did not set expired output high");

   a_expired_hold: assert property (@(posedge clk) disable iff (!nrst)   // see R15
      !watchdog_expired_n && !kick_edge && !low_s |=> !watchdog_expired_n)
      else $error("expired output rose without kick");

   a_float_quiet: assert property (@(posedge clk) disable iff (!nrst)   // see R10
      reset_n && !kick_active && !low_s |=> reset_n)
      else $error("reset issued while kick floating");

   a_tick_gap: assert property (@(posedge clk) disable iff (!nrst)   // see R13
      s_tick_int |-> !tick)
      else $error("internal ticks too close");

   a_ext_tick: assert property (@(posedge clk) disable iff (!nrst)   // see R14
      s_tick_ext |-> !tick)
      else $error("external edge counted twice");
endmodule : srw_supervisor

/* File: srw_supervisor_tb_top.sv */
// Purpose: self checking bench for the supervisor
// Assumes: divider shortened to 4 clk per tick
// Notes:   pulse lengths checked against queued notes
`timescale 1ns/1ps
module srw_supervisor_tb_top;
   import srw_pkg::*;
   localparam int D = 4;
   localparam int TI = 2 * D + 8;
   localparam int TE = 24;
   logic       clk = 0, nrst = 0, supply_low = 0, sel = 1, tb_in = 0;
   logic       ce_in_n = 1, kick_req = 0, float_en = 0, ext_en = 0, sl_p = 0;
   logic [1:0] kick;
   logic       reset_n, reset, supply_low_n, wdo_n, ce_out_n;
   int         errors = 0, cmp_count = 0, seed = 90266, cyc = 0;
   int         lowlen = 0, stab = 0, ecnt = 0, n, e, t;
   int         q_exp[$], q_tol[$];

   srw_supervisor #(.DIV(D)) dut (.clk(clk), .nrst(nrst), .supply_low(supply_low),
      .watchdog_kick_in(kick), .timebase_source_select(sel), .timebase_in(tb_in),
      .ce_in_n(ce_in_n), .reset_n(reset_n), .reset(reset), .supply_low_n(supply_low_n),
      .watchdog_expired_n(wdo_n), .ce_out_n(ce_out_n));
   srw_host host (.clk(clk), .nrst(nrst), .reset_n(reset_n), .kick_req(kick_req),
      .float_en(float_en), .kick(kick));

   always #10 clk = ~clk;

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      cmp_count++;
      if (seen !== exp || $isunknown(seen)) begin
         errors++;
         $display("MISMATCH %0t %s seen %0h exp %0h", $time, m, seen, exp);
      end
   endtask : chk
   task automatic near(input int seen, input int exp, input int tol, input string m);
      chk({31'h0, (seen >= exp - tol) && (seen <= exp + tol)}, 32'h1, m);
   endtask : near
   task automatic wait_rst(input logic v, output int c);
      c = 0;
      while (reset_n !== v && c < 40000) begin
         @(posedge clk);
         c++;
      end
      chk(reset_n, v, "reset level not reached");
   endtask : wait_rst
   task automatic do_kick();
      kick_req <= 1'b1;
      @(posedge clk);
      kick_req <= 1'b0;
   endtask : do_kick
   task automatic note(input int len, input int tol);
      q_exp.push_back(len);
      q_tol.push_back(tol);
   endtask : note
   task automatic supply_dip(input int len, input int tk, input int tol);
      note(len + RST_TICKS * tk, tol);
      supply_low <= 1'b1;
      repeat (len) @(posedge clk);
      supply_low <= 1'b0;
      wait_rst(1'b0, n);
      wait_rst(1'b1, n);
   endtask : supply_dip
   task automatic wrap_up();
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // ***************************************************************
   // stimulus side
   // ***************************************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ce_in_n <= 1'($random(seed));
      ecnt <= (ecnt + 1) % 4;
      if (ext_en && ecnt == 3) tb_in <= ~tb_in;
      if (cyc == 95000) begin
         errors++;
         wrap_up();
      end
   end

   // ***************************************************************
   // output watcher
   // ***************************************************************
   always @(posedge clk) begin
      stab = (supply_low === sl_p) ? stab + 1 : 0;
      sl_p = supply_low;
      if (cyc > 0) chk(reset, !reset_n, "reset not inverse");
      if (stab > 4) begin
         chk(supply_low_n, !supply_low, "supply low out");
         chk(ce_out_n, supply_low | ce_in_n, "chip enable gate");
         if (supply_low) chk(wdo_n, 1'b1, "expired while supply low");
         if (supply_low) chk(reset_n, 1'b0, "reset during low supply");
      end
      if (nrst && reset_n === 1'b0) lowlen++;
      if (nrst && reset_n === 1'b1 && lowlen != 0) begin
         if (q_exp.size() == 0) begin
            chk(32'h0, 32'h1, "unexpected reset pulse");
         end else begin
            e = q_exp.pop_front();
            t = q_tol.pop_front();
            near(lowlen, e, t, "reset pulse length");
         end
         lowlen = 0;
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      note(RST_TICKS * D, TI);
      wait_rst(1'b1, n);
      supply_dip(300, D, TI);
      repeat (5) begin
         repeat (1000) @(posedge clk);
         do_kick();
      end
      note(RST_TICKS * D, TI);
      wait_rst(1'b0, n);
      near(n, WD_SHORT_TICKS * D, TI, "short timeout");
      repeat (5) @(posedge clk);
      chk(wdo_n, 1'b0, "expired after timeout");
      wait_rst(1'b1, n);
      supply_dip(200, D, TI);
      tb_in <= 1'b1;
      do_kick();
      repeat (5000) @(posedge clk);
      tb_in <= 1'b0;
      float_en <= 1'b1;
      repeat (6000) @(posedge clk);
      float_en <= 1'b0;
      sel <= 1'b0;
      ext_en <= 1'b1;
      supply_dip(60, 8, TE);
      note(EXT_RST * 8, TE);
      wait_rst(1'b0, n);
      near(n, EXT_WD_LONG * 8, TE, "long timeout");
      wait_rst(1'b1, n);
      chk(wdo_n, 1'b0, "expired held");
      do_kick();
      repeat (5) @(posedge clk);
      chk(wdo_n, 1'b1, "expired cleared by kick");
      note(EXT_RST * 8, TE);
      wait_rst(1'b0, n);
      near(n, EXT_WD_NORMAL * 8, TE, "normal ext timeout");
      wait_rst(1'b1, n);
      repeat (5) @(posedge clk);
      chk(q_exp.size(), 0, "pulse notes left over");
      wrap_up();
   end
endmodule : srw_supervisor_tb_top

/* File: srw_sync.sv */
// Purpose: two flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module srw_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : srw_sync

/* File: srw_timebase.sv */
// Purpose: time base tick from internal divider or external clock pin
// Assumes: external clock already synchronised
// Notes:   external mode counts rising edges only
`timescale 1ns/1ps
module srw_timebase
   import srw_pkg::*;
#(
   parameter int unsigned DIV = OSC_DIV
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic use_internal,
   input  wire logic ext_clk_s,
   output logic      tick
);
   logic [15:0] div_q;
   logic        ext_q;

   // ***************************************************************
   // internal oscillator, about 10.24 kHz
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (!nrst || div_q == 16'(DIV - 1)) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_clk_s;
      end
   end

   assign tick = use_internal ? (div_q == 16'(DIV - 1))   // see R13
                              : (ext_clk_s && !ext_q);     // see R14
endmodule : srw_timebase
